// file: rtl/tmc_top.sv
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// How it works
// - Four units: one periodic, three compact, 10-bit
// - Counter equals comparator: interrupt, clear, pin change
// - Each unit has comparator A and P interrupts
// - Three-bit clock select field in control zero
// - Input pin counts only when selected, edge selectable
// - Compare mode: pin goes high, low or toggles
// - Edge-aligned PWM, duty or period adjustable
// - Unit 0 two pins, complementary pair; others one
// - Capture and single pulse only in unit 0
// - Route bit one gives pin to timer
// - Route bits 4..0 map units 3,2,1,0b,0a
// - Route register bits 7..5 read zero
// - Clock codes: sys/4, high, /16, /64, base, pin
// - On rising clears counter; falling holds count
module tmc_top (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Register port
   input  wire logic [5:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   // External clock and event inputs, one per unit
   input  wire logic [3:0] timer_clock_input_pin,
   // Other shared functions of the output pins
   input  wire logic [4:0] shared_func_out,
   // Output pins: 0 unit0 first, 1 unit0 second, 2..4 units 1..3
   output logic      [4:0] timer_output_pin,
   output logic      [4:0] timer_pin_routed,
   // Comparator event pulses per unit
   output logic      [3:0] cmp_a_pulse,
   output logic      [3:0] cmp_p_pulse,
   // Interrupt
   output logic            irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Register storage

   logic [7:0] c0   [4];              // Control 0 per unit
   logic [7:0] c1   [4];              // Control 1 per unit
   logic [9:0] ccra [4];              // Comparator A
   logic [9:0] ccrp [4];              // Comparator P
   logic [7:0] lbuf [4];              // Low-byte staging buffer
   logic [4:0] unit0_first_output_route;
   logic [4:0] route;                 // Pin routing bits
   logic [7:0] int_status;            // Sticky A/P events, 2 per unit
   logic [7:0] int_mask;              // Interrupt enables
   logic       pair_invert;           // Unit 0 second pin inverted

   // Per-unit signals gathered from the generate loop
   logic [9:0] cnt [4];               // Live counter values
   logic [3:0] ev_a;                  // A match or capture
   logic [3:0] ev_p;                  // P match
   logic [3:0] unit_lvl;              // Output level after polarity
   logic       cap_evt;               // Unit 0 capture strobe
   logic [7:0] events;                // Events in status layout

   // Decode
   logic       unit_hit;              // Address is inside a unit
   logic [1:0] unit_sel;              // Which unit
   logic [2:0] sub;                   // Register inside the unit

   assign unit_hit = !addr[5];
   assign unit_sel = addr[4:3];
   assign sub      = addr[2:0];

   ////////////////////////////////////////////////////////////////////////////
   // Shared clock enables

   logic tick_sys4;  // System clock / 4
   logic tick_h16;   // High clock / 16
   logic tick_h64;   // High clock / 64
   logic tick_tbc;   // Time-base clock

   // One divider per ratio, shared by all units
   tmc_div #(.DIV(tmc_pkg::DIV_SYS4)) u_div_sys4 (.clk(clk), .rst(rst), .tick(tick_sys4));
   tmc_div #(.DIV(tmc_pkg::DIV_H16))  u_div_h16  (.clk(clk), .rst(rst), .tick(tick_h16));
   tmc_div #(.DIV(tmc_pkg::DIV_H64))  u_div_h64  (.clk(clk), .rst(rst), .tick(tick_h64));
   tmc_div #(.DIV(tmc_pkg::DIV_TBC))  u_div_tbc  (.clk(clk), .rst(rst), .tick(tick_tbc));

   ////////////////////////////////////////////////////////////////////////////
   // Control registers

   // Byte writes to control registers; bits 2..0 of control 0 not built
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int u = 0; u < 4; u++)
         begin
            c0[u] <= tmc_pkg::RST_REG;
            c1[u] <= tmc_pkg::RST_REG;
         end
      end
      else if (wr_en && unit_hit)
      begin
         if (sub == tmc_pkg::SUB_C0)
            c0[unit_sel] <= wr_data & tmc_pkg::C0_MASK;
         else if (sub == tmc_pkg::SUB_C1)
            c1[unit_sel] <= wr_data;
      end
   end

   // Low-byte buffer: loaded by comparator low-byte writes and by high-byte reads
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int u = 0; u < 4; u++)
            lbuf[u] <= tmc_pkg::RST_REG;
      end
      else if (wr_en && unit_hit)
      begin
         // Staged only; committed when the high byte is written
         if (sub == tmc_pkg::SUB_AL || sub == tmc_pkg::SUB_PL)
            lbuf[unit_sel] <= wr_data;
      end
      else if (rd_en && unit_hit)
      begin
         // High read snapshots the low byte so the pair is coherent
         case (sub)
            tmc_pkg::SUB_DH: lbuf[unit_sel] <= cnt[unit_sel][7:0];
            tmc_pkg::SUB_AH: lbuf[unit_sel] <= ccra[unit_sel][7:0];
            tmc_pkg::SUB_PH: lbuf[unit_sel] <= ccrp[unit_sel][7:0];
            default:         lbuf[unit_sel] <= lbuf[unit_sel];
         endcase
      end
   end

   // Comparator A: software pair write, or capture in unit 0
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int u = 0; u < 4; u++)
            ccra[u] <= '0;
      end
      else
      begin
         if (wr_en && unit_hit && sub == tmc_pkg::SUB_AH)
            ccra[unit_sel] <= {wr_data[1:0], lbuf[unit_sel]};
         // Capture takes the slot last, so a live edge is never lost
         if (cap_evt)
            ccra[0] <= cnt[0];
      end
   end

   // Comparator P: software pair write only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int u = 0; u < 4; u++)
            ccrp[u] <= '0;
      end
      else if (wr_en && unit_hit && sub == tmc_pkg::SUB_PH)
         ccrp[unit_sel] <= {wr_data[1:0], lbuf[unit_sel]};
   end

   // Pin routing, mask and pair control
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         route       <= tmc_pkg::RST_ROUTE;
         int_mask    <= tmc_pkg::RST_REG;
         pair_invert <= 1'b0;
      end
      else if (wr_en)
      begin
         case (addr)
            tmc_pkg::ADDR_PIN_SELECT: route       <= wr_data[4:0];
            tmc_pkg::ADDR_INT_MASK:   int_mask    <= wr_data;
            tmc_pkg::ADDR_PAIR_CTRL:  pair_invert <= wr_data[0];
            default:                  route       <= route;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer units

   genvar u;
   generate
      for (u = 0; u < 4; u++)
      begin : g_unit
         localparam bit PERIODIC = (u == 0);

         logic [2:0] cks;      // Clock select field
         logic [1:0] mode;     // Operating mode
         logic [1:0] io;       // Output function
         logic       oc;       // Initial / active level
         logic       on;       // Counter on
         logic       on_q;     // Last on value
         logic       on_rise;  // Off to on
         logic       pin_q;    // Last input pin level
         logic       pin_rise; // Input rising edge
         logic       pin_fall; // Input falling edge
         logic       tick;     // Selected count enable
         logic       ma;       // Comparator A match
         logic       mp;       // Comparator P match
         logic       lvl;      // Output level

         assign cks      = c0[u][tmc_pkg::C0_CKS_LO +: 3];
         assign on       = c0[u][tmc_pkg::C0_ON];
         assign mode     = c1[u][tmc_pkg::C1_MODE_LO +: 2];
         assign io       = c1[u][tmc_pkg::C1_IO_LO +: 2];
         assign oc       = c1[u][tmc_pkg::C1_OC];
         assign on_rise  = on && !on_q;
         assign pin_rise = timer_clock_input_pin[u] && !pin_q;
         assign pin_fall = !timer_clock_input_pin[u] && pin_q;

         // Edge history for on control and input pin
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               on_q  <= 1'b0;
               pin_q <= 1'b0;
            end
            else
            begin
               on_q  <= on;
               pin_q <= timer_clock_input_pin[u];
            end
         end

         // Clock source mux; pin only reaches counter when picked
         always_comb
         begin
            case (cks)
               tmc_pkg::CKS_SYS4: tick = tick_sys4;
               tmc_pkg::CKS_H:    tick = 1'b1;
               tmc_pkg::CKS_H16:  tick = tick_h16;
               tmc_pkg::CKS_H64:  tick = tick_h64;
               tmc_pkg::CKS_TBC0: tick = tick_tbc;
               tmc_pkg::CKS_TBC1: tick = tick_tbc;
               tmc_pkg::CKS_RISE: tick = pin_rise;
               tmc_pkg::CKS_FALL: tick = pin_fall;
               default:           tick = 1'b0;
            endcase
         end

         tmc_counter u_cnt (
            .clk      (clk),
            .rst      (rst),
            .tick     (tick),
            .run      (on),
            .on_rise  (on_rise),
            .pause    (c0[u][tmc_pkg::C0_PAUSE]),
            .clr_on_a (c1[u][tmc_pkg::C1_CCLR]),
            .ccra     (ccra[u]),
            .ccrp     (ccrp[u]),
            .count    (cnt[u]),
            .match_a  (ma),
            .match_p  (mp)
         );

         // Output waveform per mode
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               lvl <= 1'b0;
            else
            begin
               case (mode)
                  tmc_pkg::MODE_CMP:
                  begin
                     if (on_rise)
                        lvl <= oc;
                     else if (ma)
                     begin
                        case (io)
                           2'h1:    lvl <= 1'b0;
                           2'h2:    lvl <= 1'b1;
                           2'h3:    lvl <= !lvl;
                           default: lvl <= lvl;
                        endcase
                     end
                  end
                  tmc_pkg::MODE_PWM:
                  begin
                     case (io)
                        2'h0: lvl <= !oc;
                        2'h1: lvl <= oc;
                        // Edge aligned: active from clear up to A
                        2'h2: lvl <= (cnt[u] < ccra[u]) ? oc : !oc;
                        default:
                        begin
                           // Single pulse exists in unit 0 only
                           if (!PERIODIC)
                              lvl <= !oc;
                           else if (on_rise)
                              lvl <= oc;
                           else if (ma)
                              lvl <= !oc;
                        end
                     endcase
                  end
                  // Capture and plain timer leave the pin alone
                  default: lvl <= lvl;
               endcase
            end
         end

         // Capture edge by io: rise, fall, both, none; unit 0 only
         if (PERIODIC)
         begin : g_cap
            always_comb
            begin
               cap_evt = 1'b0;
               if (on && mode == tmc_pkg::MODE_CAP)
               begin
                  case (io)
                     2'h0:    cap_evt = pin_rise;
                     2'h1:    cap_evt = pin_fall;
                     2'h2:    cap_evt = pin_rise || pin_fall;
                     default: cap_evt = 1'b0;
                  endcase
               end
            end
         end

         assign ev_a[u]     = ma || (PERIODIC && cap_evt);
         assign ev_p[u]     = mp;
         assign unit_lvl[u] = lvl ^ c1[u][tmc_pkg::C1_POL];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pins

   logic [4:0] timer_lvl; // Timer levels in route-bit order

   // Unit 0 drives a pair; second may be inverted for complement
   assign timer_lvl = {unit_lvl[3], unit_lvl[2], unit_lvl[1],
                       unit_lvl[0] ^ pair_invert, unit_lvl[0]};

   // Pins hold their other function until routed
   assign unit0_first_output_route = route;
   assign timer_output_pin = (timer_lvl & route) | (shared_func_out & ~route);
   assign timer_pin_routed = unit0_first_output_route;
   assign cmp_a_pulse      = ev_a;
   assign cmp_p_pulse      = ev_p;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts

   // Status bit 2u is unit u A, 2u+1 is unit u P
   always_comb
   begin
      for (int k = 0; k < 4; k++)
      begin
         events[2*k]   = ev_a[k];
         events[2*k+1] = ev_p[k];
      end
   end

   // Sticky; write one clears; a new event wins over the clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         int_status <= tmc_pkg::RST_REG;
      else if (wr_en && addr == tmc_pkg::ADDR_INT_STATUS)
         int_status <= (int_status & ~wr_data) | events;
      else
         int_status <= int_status | events;
   end

   // Level request while any unmasked event stands
   assign irq = |(int_status & int_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Read port

   // Data appear the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rd_data <= tmc_pkg::RST_REG;
      else if (rd_en && unit_hit)
      begin
         case (sub)
            tmc_pkg::SUB_C0: rd_data <= c0[unit_sel];
            tmc_pkg::SUB_C1: rd_data <= c1[unit_sel];
            tmc_pkg::SUB_DH: rd_data <= {6'h00, cnt[unit_sel][9:8]};
            tmc_pkg::SUB_AH: rd_data <= {6'h00, ccra[unit_sel][9:8]};
            tmc_pkg::SUB_PH: rd_data <= {6'h00, ccrp[unit_sel][9:8]};
            // Low bytes come from the buffer
            default:         rd_data <= lbuf[unit_sel];
         endcase
      end
      else if (rd_en)
      begin
         case (addr)
            tmc_pkg::ADDR_PIN_SELECT: rd_data <= {3'h0, route};
            tmc_pkg::ADDR_INT_STATUS: rd_data <= int_status;
            tmc_pkg::ADDR_INT_MASK:   rd_data <= int_mask;
            tmc_pkg::ADDR_PAIR_CTRL:  rd_data <= {7'h00, pair_invert};
            default:                  rd_data <= 8'h00;
         endcase
      end
      else
         rd_data <= 8'h00;
   end

endmodule : tmc_top

// file: rtl/tmc_pkg.sv
package tmc_pkg;

   // Register map: four units of eight byte registers, then shared ones
   localparam logic [2:0] SUB_C0  = 3'h0; // Control 0: pause, clock, on
   localparam logic [2:0] SUB_C1  = 3'h1; // Control 1: mode, output, clear
   localparam logic [2:0] SUB_DL  = 3'h2; // Counter low byte (via buffer)
   localparam logic [2:0] SUB_DH  = 3'h3; // Counter high bits
   localparam logic [2:0] SUB_AL  = 3'h4; // Comparator A low byte
   localparam logic [2:0] SUB_AH  = 3'h5; // Comparator A high bits
   localparam logic [2:0] SUB_PL  = 3'h6; // Comparator P low byte
   localparam logic [2:0] SUB_PH  = 3'h7; // Comparator P high bits
   localparam logic [5:0] ADDR_PIN_SELECT = 6'h20; // Output pin routing
   localparam logic [5:0] ADDR_INT_STATUS = 6'h21; // Sticky events
   localparam logic [5:0] ADDR_INT_MASK   = 6'h22; // Interrupt mask
   localparam logic [5:0] ADDR_PAIR_CTRL  = 6'h23; // Unit 0 pair polarity

   // Control 0 fields
   localparam int C0_PAUSE  = 7;
   localparam int C0_CKS_LO = 4;
   localparam int C0_ON     = 3;
   localparam logic [7:0] C0_MASK = 8'hF8; // Bits 2..0 not built

   // Control 1 fields
   localparam int C1_MODE_LO = 6;
   localparam int C1_IO_LO   = 4;
   localparam int C1_OC      = 3;
   localparam int C1_POL     = 2;
   localparam int C1_CCLR    = 0;

   // Reset values
   localparam logic [7:0] RST_REG   = 8'h00;
   localparam logic [4:0] RST_ROUTE = 5'h00;

   // Clock select codes
   localparam logic [2:0] CKS_SYS4 = 3'h0;
   localparam logic [2:0] CKS_H    = 3'h1;
   localparam logic [2:0] CKS_H16  = 3'h2;
   localparam logic [2:0] CKS_H64  = 3'h3;
   localparam logic [2:0] CKS_TBC0 = 3'h4;
   localparam logic [2:0] CKS_TBC1 = 3'h5;
   localparam logic [2:0] CKS_RISE = 3'h6;
   localparam logic [2:0] CKS_FALL = 3'h7;

   // Operating modes
   localparam logic [1:0] MODE_CMP = 2'h0;
   localparam logic [1:0] MODE_CAP = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TMR = 2'h3;

   // Divider ratios in clock cycles
   localparam int DIV_SYS4 = 4;
   localparam int DIV_H16  = 16;
   localparam int DIV_H64  = 64;
   localparam int DIV_TBC  = 1024;

   // Counter width
   localparam int CNT_W = 10;

endpackage : tmc_pkg

// file: rtl/tmc_div.sv
`timescale 1ns/1ps
// Free-running divider: one-cycle enable pulse every DIV cycles
module tmc_div #(
   parameter int DIV = 4
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Enable pulse
   output logic      tick
);

   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] count; // Position within the period

   // Count up and wrap on the last step
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         count <= '0;
         tick  <= 1'b0;
      end
      else
      begin
         tick  <= (count == LAST);
         count <= (count == LAST) ? '0 : count + 1'b1;
      end
   end

endmodule : tmc_div

// file: rtl/tmc_counter.sv
`timescale 1ns/1ps
// Ten-bit up counter with comparators A and P
module tmc_counter (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // Control
   input  wire logic                     tick,
   input  wire logic                     run,
   input  wire logic                     on_rise,
   input  wire logic                     pause,
   input  wire logic                     clr_on_a,
   // Comparator values
   input  wire logic [tmc_pkg::CNT_W-1:0] ccra,
   input  wire logic [tmc_pkg::CNT_W-1:0] ccrp,
   // State and match pulses
   output logic      [tmc_pkg::CNT_W-1:0] count,
   output logic                          match_a,
   output logic                          match_p
);

   logic step; // Counter advances this cycle

   // Only a live clock edge while running and not paused can match
   assign step    = tick && run && !pause && !on_rise;
   assign match_a = step && (count == ccra);
   assign match_p = step && (count == ccrp);

   // Off-to-on clears, off holds, match may clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         count <= '0;
      else if (on_rise)
         count <= '0;
      else if (step)
      begin
         if (clr_on_a ? match_a : match_p)
            count <= '0;
         else
            count <= count + 1'b1;
      end
   end

endmodule : tmc_counter

// file: bench/tmc_pin_model.sv
`timescale 1ns/1ps
// Far side: count pins and the other pin functions
module tmc_pin_model #(
   parameter int HALF = 3 // Pin half period in clocks
) (
   // Clock and control
   input  wire logic       clk,
   input  wire logic       run,
   // Driven levels
   output logic      [3:0] ext_pin,
   output logic      [4:0] shared
);
   int ph = 0; // Phase within a half period
   initial
   begin
      ext_pin = 4'h0;
      shared  = 5'h15;
   end
   // Count pins toggle only while run; they stand still otherwise
   always @(posedge clk)
   begin
      shared <= {shared[3:0], ~shared[4]}; // Moves each cycle so a stuck mux shows
      if (run)
      begin
         ph <= (ph == HALF - 1) ? 0 : ph + 1;
         if (ph == HALF - 1)
            ext_pin <= ~ext_pin;
      end
   end
endmodule : tmc_pin_model

// file: bench/tmc_properties.sv
`timescale 1ns/1ps
// Port checks: routing, read port, events, interrupt
module tmc_properties (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Register port
   input wire logic [5:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] rd_data,
   // Pins and events
   input wire logic [4:0] shared_func_out,
   input wire logic [4:0] timer_output_pin,
   input wire logic [4:0] timer_pin_routed,
   input wire logic [3:0] cmp_a_pulse,
   input wire logic [3:0] cmp_p_pulse,
   input wire logic       irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic pair_q; // Mirror of the unit 0 pair bit
   logic ev_q;   // Any A or P event (match or capture) last cycle
   logic mw_q;   // Mask write last cycle
   ////////////////////////////////////////////////////////////
   // Helper state, kept apart from the design's own
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         pair_q <= 1'b0;
         ev_q   <= 1'b0;
         mw_q   <= 1'b0;
      end
      else
      begin
         if (wr_en && addr == tmc_pkg::ADDR_PAIR_CTRL)
            pair_q <= wr_data[0];
         ev_q <= |{cmp_a_pulse, cmp_p_pulse};
         mw_q <= wr_en && addr == tmc_pkg::ADDR_INT_MASK;
      end
   ////////////////////////////////////////////////////////////
   a_route_mux: assert property (((timer_output_pin ^ shared_func_out) & ~timer_pin_routed) == 5'h00)
      else $error("unrouted pin differs from shared level");
   a_route_write: assert property (wr_en && addr == tmc_pkg::ADDR_PIN_SELECT |=>
      {3'h0, timer_pin_routed} == ($past(wr_data) & 8'h1f)) else $error("routing not written");
   a_route_read: assert property (rd_en && addr == tmc_pkg::ADDR_PIN_SELECT |=>
      rd_data == {3'h0, $past(timer_pin_routed)}) else $error("routing read wrong");
   a_read_idle: assert property (!rd_en |=> rd_data == 8'h00)
      else $error("read data outside read slot");
   a_off_quiet: assert property (wr_en && addr == 6'h08 && !wr_data[3] |=>
      (!cmp_a_pulse[1] && !cmp_p_pulse[1]) [*2]) else $error("match while off");
   a_irq_rise: assert property ($rose(irq) |-> ev_q || mw_q)
      else $error("interrupt without cause");
   a_irq_fall: assert property ($fell(irq) |-> $past(wr_en))
      else $error("interrupt dropped without write");
   a_pair_comp: assert property (&timer_pin_routed[1:0] |->
      timer_output_pin[1] == (timer_output_pin[0] ^ pair_q)) else $error("pair not complementary");
   // Main scenarios reached
   c_match: cover property (cmp_a_pulse[1]);
   c_irq: cover property (irq);
   c_routed: cover property (&timer_pin_routed);
endmodule : tmc_properties
bind tmc_top tmc_properties u_chk (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
   .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .shared_func_out(shared_func_out),
   .timer_output_pin(timer_output_pin), .timer_pin_routed(timer_pin_routed),
   .cmp_a_pulse(cmp_a_pulse), .cmp_p_pulse(cmp_p_pulse), .irq(irq));

// file: bench/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   begin \
      checks_done++; \
      if ((got) !== (ex)) \
      begin \
         bad_count++; \
         $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
      end \
   end
module testbench;
   localparam int HALF = 3; // Pin half period
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [5:0] addr = 6'h00;
   logic [7:0] wr_data = 8'h00;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic       pin_run = 1'b0; // Far side pins moving
   logic [7:0] rd_data, got;
   logic [3:0] ext_pin, pa, pp;
   logic [4:0] shared, pins, routed;
   logic       irq, v;
   int         bad_count = 0;
   int         checks_done = 0;
   int         n;
   always #10 clk = ~clk;
   tmc_pin_model #(.HALF(HALF)) u_pins (.clk(clk), .run(pin_run), .ext_pin(ext_pin), .shared(shared));
   tmc_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .timer_clock_input_pin(ext_pin), .shared_func_out(shared),
      .timer_output_pin(pins), .timer_pin_routed(routed), .cmp_a_pulse(pa), .cmp_p_pulse(pp), .irq(irq));
   ////////////////////////////////////////////////////////////
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr
   // Data lands one cycle after the strobe, sampled once settled
   task automatic rd(input logic [5:0] a);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 got = rd_data;
   endtask : rd
   // Cycles to the next match of unit u; bounded so a hang ends
   task automatic wait_ev(input int u, input bit p, output int k);
      k = 0;
      do
      begin
         @(posedge clk);
         #1 k++;
      end while (!(p ? pp[u] : pa[u]) && k < 5000);
   endtask : wait_ev
   task automatic t_route;
      for (int i = 0; i < 5; i++)
      begin
         wr(tmc_pkg::ADDR_PIN_SELECT, 8'he0 | (8'h01 << i));
         rd(tmc_pkg::ADDR_PIN_SELECT);
         `CHK("route rd", 8'h01 << i, got)
         `CHK("pins", shared & ~(5'h01 << i), pins)
      end
      wr(tmc_pkg::ADDR_PIN_SELECT, 8'h03);
      wr(tmc_pkg::ADDR_PAIR_CTRL, 8'h01);
      #1 `CHK("pair", 2'h2, pins[1:0])
      wr(tmc_pkg::ADDR_PIN_SELECT, 8'h00);
   endtask : t_route
   // Unit 1: A = 3 clears the counter, pin driven by io code
   task automatic t_compare;
      wr(6'h0c, 8'h03);
      wr(6'h0d, 8'h00);
      wr(6'h09, 8'h21);
      wr(tmc_pkg::ADDR_PIN_SELECT, 8'h04);
      wr(6'h08, 8'h18);
      #1 `CHK("pin init", 1'b0, pins[2])
      wait_ev(1, 1'b0, n);
      wait_ev(1, 1'b0, n);
      `CHK("a period", 4, n)
      @(posedge clk);
      #1 `CHK("pin high", 1'b1, pins[2])
      wr(6'h09, 8'h11);
      wait_ev(1, 1'b0, n);
      @(posedge clk);
      #1 `CHK("pin low", 1'b0, pins[2])
      wr(6'h09, 8'h31);
      wait_ev(1, 1'b0, n);
      @(posedge clk);
      #1 v = pins[2];
      wait_ev(1, 1'b0, n);
      @(posedge clk);
      #1 `CHK("toggle", ~v, pins[2])
      `CHK("irq masked", 1'b0, irq)
      wr(tmc_pkg::ADDR_INT_MASK, 8'h04);
      #1 `CHK("irq", 1'b1, irq)
      wr(6'h08, 8'h00);
      rd(tmc_pkg::ADDR_INT_STATUS);
      `CHK("status", 8'h04, got & 8'h04)
      wr(tmc_pkg::ADDR_INT_STATUS, 8'h04);
      #1 `CHK("irq clear", 1'b0, irq)
   endtask : t_compare
   // Unit 2: P = 1, so matches come every second count tick
   task automatic t_clocks;
      int ex [8];
      ex = '{2 * tmc_pkg::DIV_SYS4, 2, 2 * tmc_pkg::DIV_H16, 2 * tmc_pkg::DIV_H64,
             2 * tmc_pkg::DIV_TBC, 2 * tmc_pkg::DIV_TBC, 4 * HALF, 4 * HALF};
      pin_run <= 1'b1;
      wr(6'h16, 8'h01);
      wr(6'h17, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         wr(6'h10, 8'h08 | 8'(c << 4));
         wait_ev(2, 1'b1, n);
         wait_ev(2, 1'b1, n);
         `CHK("tick period", ex[c], n)
      end
      pin_run <= 1'b0;
      wait_ev(2, 1'b1, n);
      `CHK("still pin", 5000, n)
   endtask : t_clocks
   // Unit 3: edge-aligned PWM, A = 2 sets duty, P = 5 sets period
   task automatic t_pwm;
      wr(6'h1c, 8'h02);
      wr(6'h1d, 8'h00);
      wr(6'h1e, 8'h05);
      wr(6'h1f, 8'h00);
      rd(6'h1d);
      `CHK("a high", 8'h00, got)
      rd(6'h1c);
      `CHK("a low", 8'h02, got)
      wr(6'h19, 8'ha8);
      wr(tmc_pkg::ADDR_PIN_SELECT, 8'h10);
      wr(6'h18, 8'h18);
      wait_ev(3, 1'b1, n);
      n = 0;
      repeat (6)
      begin
         @(posedge clk);
         #1 n += pins[4];
      end
      `CHK("pwm duty", 2, n)
      wr(6'h18, 8'h00);
   endtask : t_pwm
   task automatic complete_run;
      if (bad_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(tmc_pkg::ADDR_PIN_SELECT);
      `CHK("route reset", 8'h00, got)
      t_route();
      t_compare();
      t_clocks();
      t_pwm();
      complete_run();
   end
   // Watchdog well past the expected run length
   initial
   begin
      #1200000;
      bad_count++;
      complete_run();
   end
endmodule : testbench
